// file: src/bmr_pkg.sv
// Purpose: Shared constants, types and sentinels of the breaker register map server.
// Assumes: Register numbers are decimal; frame address is the register number minus one.
// Notes: Timing counts derive from the 50 MHz system clock.
package bmr_pkg;
   // Register map regions, in register numbers.
   localparam int DS_FIRST = 32000;
   localparam int DS_LAST = 32341;
   localparam int DS_WORDS = DS_LAST - DS_FIRST + 1;
   localparam int DATE_SEC_HI = 2900;
   localparam int DATE_SEC_LO = 2901;
   localparam int DATE_MSQ = 2902;
   localparam int REG_TO_ADDR = 1;
   localparam int MAX_REGS = 125;
   // Variables that must be read whole, as first register and length.
   localparam int NBLK = 3;
   localparam int BLK_FIRST [NBLK] = '{32096, 32028, DATE_SEC_HI};
   localparam int BLK_LEN [NBLK] = '{4, 2, 2};
   // Function and exception codes.
   localparam logic [7:0] FN_RD_HOLD = 8'h03;
   localparam logic [7:0] FN_RD_INPUT = 8'h04;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILL_FN = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_VAL = 8'h03;
   // Millisecond word layout.
   localparam int MS_W = 10;
   localparam int Q_EXT_BIT = 12;
   localparam int Q_INT_BIT = 13;
   localparam int Q_ABS_BIT = 14;
   localparam int MS_PER_S = 1000;
   // Timing: external sync stays fresh for two hours.
   localparam int SYNC_HOLD_S = 7200;
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PERIOD_US = 1000;
   localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_PERIOD_US;
   // Sentinel values, right aligned.
   localparam logic [63:0] SN_U16 = 64'h0000_0000_0000_FFFF;
   localparam logic [63:0] SN_S16 = 64'h0000_0000_0000_8000;
   localparam logic [63:0] SN_U32 = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] SN_S32 = 64'h0000_0000_8000_0000;
   localparam logic [63:0] SN_U64 = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] SN_S64 = 64'h8000_0000_0000_0000;
   localparam logic [63:0] SN_F32 = 64'h0000_0000_FFC0_0000;

   typedef enum logic [3:0] {
      SC_U16, SC_S16, SC_U32, SC_S32, SC_U64, SC_S64, SC_F32,
      SC_LEG16, SC_LEG32, SC_NEUTRAL
   } bmr_class_t;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01, ST_EXC = 2'b10} bmr_state_t;

   typedef struct packed {
      logic [7:0] fn;
      logic [15:0] addr;
      logic [15:0] count;
   } bmr_req_t;

   typedef struct packed {
      logic valid;
      logic exc;
      logic last;
      logic [7:0] code;
      logic [15:0] word;
   } bmr_rsp_t;

   typedef struct packed {
      logic valid;
      logic [8:0] index;
      logic [2:0] words;
      logic na;
      bmr_class_t sc;
      logic [63:0] data;
   } bmr_wr_t;

   typedef struct packed {
      logic valid;
      logic external;
      logic [31:0] seconds;
      logic [9:0] ms;
   } bmr_sync_t;
endpackage : bmr_pkg

// file: src/bmr_server.sv
// Purpose: Register map server answering read requests for the breaker dataset and date.
// Assumes: Framing and CRC are handled outside; one request is served at a time.
// Notes: One register word leaves per clock; exceptions leave as one word.
// Functional notes
// - Each type spans fixed registers: 16-bit one, 32-bit two; client asks that many.
// - A read covering only part of a multi-register block is answered with an error; the server checks only the three blocks in BLK_FIRST.
// - A read touching any unmapped register number gets an exception, not data.
// - Neutral-dependent values read 32768 when neutral configuration makes them meaningless.
// - Invalid values use type sentinels: all ones, most negative, or quiet NaN.
// - Legacy words may use 0x8000 or 0x80000000 as their invalid marker.
// - Dataset sits at registers 32000 to 32341, refreshed by the module periodically.
// - One read covers at most 125 registers; longer ones are refused.
// - Frame address equals register number minus one.
// - Only plain read functions are served; command-only access is refused.
// - Multi-register values go out most significant register first.
// - 64-bit values are four 16-bit words, signed or unsigned two's complement.
// - Floats are IEEE single precision words passed through unchanged.
// - Registers 2900-2901 hold seconds since 2000; 2902 holds ms and quality.
// - Ms word: bits 0-9 ms, bit 12 external, 13 internal, 14 absolute set.
// - Reset restarts seconds at the 2000 epoch; a sync reloads them.
// - A validity word may precede a bit-enumerated word, one bit per bit.
`timescale 1ns/100ps
module bmr_server #(
   parameter int MS_CYCLES = bmr_pkg::MS_CYCLES,
   parameter int MAX_REGS = bmr_pkg::MAX_REGS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Read request from the framing layer.
   input wire logic req_valid,
   input wire bmr_pkg::bmr_req_t req,
   output logic req_ready,
   // Response words toward the framing layer.
   output bmr_pkg::bmr_rsp_t rsp,
   // Dataset refresh from the monitoring module.
   input wire bmr_pkg::bmr_wr_t wr,
   input wire logic neutral_absent,
   // Date synchronisation.
   input wire bmr_pkg::bmr_sync_t sync,
   input wire logic internal_sync
);
   import bmr_pkg::*;

   // Elaboration checks on parameters.
   if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_ms
      $error("MS_CYCLES must be between 1 and 65536");
   end
   if (MAX_REGS < 1 || MAX_REGS > 255) begin : g_bad_max
      $error("MAX_REGS must be between 1 and 255");
   end

   typedef struct packed {
      bmr_state_t state;
      logic ready;
      bmr_rsp_t rsp;
      logic [15:0] ptr;
      logic [7:0] remain;
      logic [7:0] fn;
      logic [7:0] exc;
      logic [DS_WORDS-1:0][15:0] ds;
      logic [15:0] ms_div;
      logic [9:0] ms;
      logic [31:0] secs;
      logic [12:0] ext_left;
      logic q_int;
      logic q_abs;
      logic [31:0] snap_sec;
      logic [15:0] snap_msq;
   } bmr_st_t;

   bmr_st_t s;
   bmr_st_t next_s;

   // Checks function, range and block integrity; returns an exception code or none.
   function automatic logic [7:0] check_req(bmr_req_t r);
      int f;
      int l;
      int b1;
      logic [7:0] code;
      f = int'(r.addr) + REG_TO_ADDR;
      l = f + int'(r.count) - 1;
      code = EXC_NONE;
      if (r.fn != FN_RD_HOLD && r.fn != FN_RD_INPUT) begin
         code = EXC_ILL_FN;
      end else if (r.count == 16'h0000 || int'(r.count) > MAX_REGS) begin
         code = EXC_ILL_VAL;
      end else if (!((f >= DS_FIRST && l <= DS_LAST) || (f >= DATE_SEC_HI && l <= DATE_MSQ))) begin
         code = EXC_ILL_ADDR;
      end else begin
         for (int b = 0; b < NBLK; b++) begin
            b1 = BLK_FIRST[b] + BLK_LEN[b] - 1;
            // A block must be taken whole, since its words are one value.
            if (f <= b1 && l >= BLK_FIRST[b] && (f > BLK_FIRST[b] || l < b1)) begin
               code = EXC_ILL_ADDR;
            end
         end
      end
      return code;
   endfunction : check_req

   // Sentinel for a class, right aligned within the written words.
   function automatic logic [63:0] sentinel(bmr_class_t sc);
      logic [63:0] v;
      v = SN_U16;
      unique case (sc)
         SC_U16: v = SN_U16;
         SC_S16: v = SN_S16;
         SC_U32: v = SN_U32;
         SC_S32: v = SN_S32;
         SC_U64: v = SN_U64;
         SC_S64: v = SN_S64;
         SC_F32: v = SN_F32;
         SC_LEG16: v = SN_S16;
         SC_LEG32: v = SN_S32;
         SC_NEUTRAL: v = SN_S16;
         default: v = SN_U16;
      endcase
      return v;
   endfunction : sentinel

   // Word served for a register number; dataset or date snapshot.
   function automatic logic [15:0] word_at(bmr_st_t st, logic [15:0] r);
      logic [15:0] w;
      w = 16'h0000;
      if (int'(r) >= DS_FIRST) begin
         w = st.ds[9'(int'(r) - DS_FIRST)];
      end else if (int'(r) == DATE_SEC_HI) begin
         w = st.snap_sec[31:16];
      end else if (int'(r) == DATE_SEC_LO) begin
         w = st.snap_sec[15:0];
      end else begin
         w = st.snap_msq;
      end
      return w;
   endfunction : word_at

   // Next-state logic: date clock, dataset refresh and request sequencing.
   always_comb begin
      logic [63:0] val;
      logic [7:0] code;
      val = 64'h0;
      code = EXC_NONE;
      next_s = s;
      next_s.rsp = '0;

      // Millisecond and second counting; reset means the 2000 epoch.
      if (int'(s.ms_div) == MS_CYCLES - 1) begin
         next_s.ms_div = 16'h0000;
         if (int'(s.ms) == MS_PER_S - 1) begin
            next_s.ms = 10'h000;
            next_s.secs = s.secs + 32'h0000_0001;
            if (s.ext_left != 13'h0000) begin
               next_s.ext_left = s.ext_left - 13'h0001;
            end
         end else begin
            next_s.ms = s.ms + 10'h001;
         end
      end else begin
         next_s.ms_div = s.ms_div + 16'h0001;
      end

      // A sync reloads the counter and marks date quality.
      if (sync.valid) begin
         next_s.secs = sync.seconds;
         next_s.ms = sync.ms;
         next_s.ms_div = 16'h0000;
         next_s.q_abs = 1'b1;
         if (sync.external) begin
            next_s.ext_left = 13'(SYNC_HOLD_S);
         end
      end
      if (internal_sync) begin
         next_s.q_int = 1'b1;
      end

      // Refresh: value is split most significant word at the lowest register.
      // A validity word before a bit field is written like any other word.
      if (wr.valid) begin
         val = wr.data;
         if (wr.na || (wr.sc == SC_NEUTRAL && neutral_absent)) begin
            val = sentinel(wr.sc);
         end
         for (int k = 0; k < 4; k++) begin
            if (k < int'(wr.words) && int'(wr.index) + k < DS_WORDS) begin
               next_s.ds[9'(int'(wr.index) + k)] =
                  16'(val >> (16 * (int'(wr.words) - 1 - k)));
            end
         end
      end

      // Request sequencing.
      unique case (s.state)
         ST_IDLE: begin
            next_s.ready = 1'b1;
            if (req_valid && s.ready) begin
               code = check_req(req);
               next_s.ready = 1'b0;
               next_s.fn = req.fn;
               next_s.exc = code;
               next_s.ptr = req.addr + 16'(REG_TO_ADDR);
               next_s.remain = req.count[7:0];
               // Snapshot keeps the three date words coherent within one answer.
               next_s.snap_sec = s.secs;
               next_s.snap_msq = 16'h0000;
               next_s.snap_msq[MS_W-1:0] = s.ms;
               next_s.snap_msq[Q_EXT_BIT] = (s.ext_left != 13'h0000);
               next_s.snap_msq[Q_INT_BIT] = s.q_int;
               next_s.snap_msq[Q_ABS_BIT] = s.q_abs;
               next_s.state = (code == EXC_NONE) ? ST_SEND : ST_EXC;
            end
         end
         ST_SEND: begin
            next_s.rsp.valid = 1'b1;
            next_s.rsp.code = s.fn;
            next_s.rsp.word = word_at(s, s.ptr);
            next_s.ptr = s.ptr + 16'h0001;
            next_s.remain = s.remain - 8'h01;
            if (s.remain == 8'h01) begin
               next_s.rsp.last = 1'b1;
               next_s.ready = 1'b1;
               next_s.state = ST_IDLE;
            end
         end
         ST_EXC: begin
            next_s.rsp.valid = 1'b1;
            next_s.rsp.exc = 1'b1;
            next_s.rsp.last = 1'b1;
            next_s.rsp.code = s.fn | EXC_FLAG;
            next_s.rsp.word = {8'h00, s.exc};
            next_s.ready = 1'b1;
            next_s.state = ST_IDLE;
         end
         // The unused code falls back to idle rather than locking the server.
         default: begin
            next_s.ready = 1'b0;
            next_s.state = ST_IDLE;
         end
      endcase
   end

   // State register; reset clears the date to the epoch and empties the dataset.
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign req_ready = s.ready;
   assign rsp = s.rsp;
endmodule : bmr_server

// file: tb/bmr_server_monitor.sv
// Purpose: Port assertions for the register map server.
// Assumes: Rising clk, synchronous active-high rst.
// Notes: Bound to every server instance at the foot of this file.
`timescale 1ns/100ps
module bmr_server_monitor import bmr_pkg::*; #(
   parameter int MS_CYCLES = bmr_pkg::MS_CYCLES,
   parameter int MAX_REGS = bmr_pkg::MAX_REGS
) (
   // Every server port, watched only.
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire bmr_pkg::bmr_req_t req,
   input wire logic req_ready,
   input wire bmr_pkg::bmr_rsp_t rsp,
   input wire bmr_pkg::bmr_wr_t wr,
   input wire logic neutral_absent,
   input wire bmr_pkg::bmr_sync_t sync,
   input wire logic internal_sync
);
   int first, last, exp_n, got_n;
   logic take, fn_ok, len_ok, addr_ok;
   // Request classification, worked out independently of the server.
   assign take = req_valid && req_ready;
   assign fn_ok = req.fn == FN_RD_HOLD || req.fn == FN_RD_INPUT;
   assign len_ok = req.count != 16'h0000 && int'(req.count) <= MAX_REGS;
   // A legal span stays in one region and never cuts a whole-read block.
   always_comb begin
      first = int'(req.addr) + REG_TO_ADDR;
      last = first + int'(req.count) - 1;
      addr_ok = (first >= DS_FIRST && last <= DS_LAST) ||
                (first >= DATE_SEC_HI && last <= DATE_MSQ);
      for (int i = 0; i < NBLK; i++) begin
         if (first <= BLK_FIRST[i] + BLK_LEN[i] - 1 && last >= BLK_FIRST[i] &&
             (first > BLK_FIRST[i] || last < BLK_FIRST[i] + BLK_LEN[i] - 1)) begin
            addr_ok = 1'b0;
         end
      end
   end
   // Counts words of the answer in flight, so a short or long burst is caught.
   always_ff @(posedge clk) begin
      if (rst) begin
         exp_n <= 0;
         got_n <= 0;
      end else if (take) begin
         exp_n <= int'(req.count);
         got_n <= 0;
      end else if (rsp.valid) begin
         got_n <= got_n + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // The server registers the request first, so the first answer word is sampled two edges on.
   ans_next_a: assert property (take |-> ##2 rsp.valid)
      else $error("no answer word after a taken request");
   bad_fn_a: assert property (take && !fn_ok |-> ##2 rsp.exc &&
      rsp.word == {8'h00, EXC_ILL_FN}) else $error("unsupported function not refused");
   long_req_a: assert property (take && fn_ok && !len_ok |-> ##2 rsp.exc &&
      rsp.word == {8'h00, EXC_ILL_VAL}) else $error("bad count not refused");
   addr_exc_a: assert property (take && fn_ok && len_ok && !addr_ok |->
      ##2 rsp.exc && rsp.word == {8'h00, EXC_ILL_ADDR} &&
      rsp.code == ($past(req.fn, 2) | EXC_FLAG))
      else $error("bad span not refused with address code");
   good_data_a: assert property (take && fn_ok && len_ok && addr_ok |->
      ##2 !rsp.exc && rsp.code == $past(req.fn, 2)) else $error("legal read refused");
   word_count_a: assert property (rsp.valid && rsp.last && !rsp.exc |-> got_n + 1 == exp_n)
      else $error("word count differs from request");
   ready_low_a: assert property (rsp.valid && !rsp.last |-> !req_ready)
      else $error("ready while answer still running");
   burst_on_a: assert property (rsp.valid && !rsp.last |=> rsp.valid)
      else $error("gap inside answer burst");
   exc_one_a: assert property (rsp.valid && rsp.exc |-> rsp.last && req_ready && rsp.code[7])
      else $error("exception not a single flagged word");
   cover property (take && fn_ok && len_ok && !addr_ok);
   cover property (rsp.valid && rsp.last && got_n == 3);
   cover property (sync.valid && sync.external);
endmodule : bmr_server_monitor

bind bmr_server bmr_server_monitor #(.MS_CYCLES(MS_CYCLES), .MAX_REGS(MAX_REGS))
   i_bmr_server_monitor (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .rsp(rsp), .wr(wr), .neutral_absent(neutral_absent),
   .sync(sync), .internal_sync(internal_sync));

// file: tb/bmr_client.sv
// Purpose: Behavioural read client standing on the far side of the server.
// Assumes: Requests change on the falling edge and hold until taken.
// Notes: Keeps the last answer in words, exc and code for the bench.
`timescale 1ns/100ps
module bmr_client import bmr_pkg::*; (
   // Clock.
   input wire logic clk,
   // Request and answer of the server.
   output bmr_pkg::bmr_req_t req,
   output logic req_valid,
   input wire logic req_ready,
   input wire bmr_pkg::bmr_rsp_t rsp
);
   logic [15:0] words [$];
   logic exc;
   logic [7:0] code;
   int n_hung = 0;
   // Idle until the first request.
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // One read by register number; released lines are scrambled, not held.
   task automatic read(input logic [7:0] fn, input int reg_no, input int n);
      int k;
      words.delete();
      k = 0;
      @(negedge clk);
      req <= {fn, 16'(reg_no - REG_TO_ADDR), 16'(n)};
      req_valid <= 1'b1;
      do @(posedge clk); while (req_ready !== 1'b1);
      do begin
         @(negedge clk);
         req_valid <= 1'b0;
         req <= ~req;
         if (rsp.valid === 1'b1) begin
            words.push_back(rsp.word);
            exc = rsp.exc;
            code = rsp.code;
         end
         k++;
      end while (rsp.last !== 1'b1 && k < 300);
      // An answer that never ends is counted so the bench can fail on it.
      if (k >= 300) begin
         n_hung++;
      end
   endtask : read
endmodule : bmr_client

// file: tb/tb_bmr_server.sv
// Purpose: Self-checking bench for the register map server.
// Assumes: Short millisecond divider of four clocks.
// Notes: Inputs change on the falling edge.
`timescale 1ns/100ps
module tb_bmr_server;
   import bmr_pkg::*;
   logic clk, rst, req_valid, req_ready, neutral_absent, internal_sync;
   bmr_req_t req;
   bmr_rsp_t rsp;
   bmr_wr_t wr;
   bmr_sync_t sync;
   int n_fail = 0;
   int num_checks = 0;
   logic [63:0] v;
   localparam logic [63:0] SN [10] = '{SN_U16, SN_S16, SN_U32, SN_S32, SN_U64, SN_S64,
      SN_F32, SN_S16, SN_S32, SN_S16};
   localparam int NW [10] = '{1, 1, 2, 2, 4, 4, 2, 1, 2, 1};
   bmr_server #(.MS_CYCLES(4), .MAX_REGS(MAX_REGS)) i_bmr_server (.clk(clk), .rst(rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp), .wr(wr),
      .neutral_absent(neutral_absent), .sync(sync), .internal_sync(internal_sync));
   bmr_client i_bmr_client (.clk(clk), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .rsp(rsp));
   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [15:0] w(input int k);
      return i_bmr_client.words[k];
   endfunction : w
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      n_fail += i_bmr_client.n_hung;
      $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   task automatic put(input int idx, input int n, input logic na, input bmr_class_t sc,
                      input logic [63:0] d);
      @(negedge clk);
      wr <= '{1'b1, 9'(idx), 3'(n), na, sc, d};
      @(negedge clk);
      wr.valid <= 1'b0;
   endtask : put
   task automatic exc_case(input logic [7:0] fn, input int reg_no, input int n,
                           input logic [7:0] ec);
      i_bmr_client.read(fn, reg_no, n);
      check({i_bmr_client.exc, i_bmr_client.code, w(0)}, {1'b1, fn | EXC_FLAG, 8'h00, ec});
   endtask : exc_case
   // Main sequence; the date is read first, while still inside second zero.
   initial begin
      rst = 1'b1;
      wr = '0;
      sync = '0;
      neutral_absent = 1'b0;
      internal_sync = 1'b0;
      repeat (20) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      i_bmr_client.read(FN_RD_HOLD, DATE_SEC_HI, 3);
      check({w(0), w(1), w(2)}, 48'h0);
      @(negedge clk) sync <= '{1'b1, 1'b1, 32'h1234_5678, 10'h005};
      @(negedge clk) sync.valid <= 1'b0;
      i_bmr_client.read(FN_RD_INPUT, DATE_SEC_HI, 3);
      check({w(0), w(1), w(2)}, 48'h1234_5678_5005);
      @(negedge clk) internal_sync <= 1'b1;
      @(negedge clk) internal_sync <= 1'b0;
      i_bmr_client.read(FN_RD_HOLD, DATE_MSQ, 1);
      check(w(0) & 16'hFC00, 16'h7000);
      put(96, 4, 1'b0, SC_S64, 64'h0000_0000_0017_9692);
      i_bmr_client.read(FN_RD_HOLD, 32096, 4);
      check({w(0), w(1), w(2), w(3)}, 64'h0000_0000_0017_9692);
      put(28, 2, 1'b0, SC_F32, 64'h440A_C000);
      i_bmr_client.read(FN_RD_INPUT, 32028, 2);
      check({w(0), w(1)}, 64'h440A_C000);
      for (int i = 0; i < 10; i++) begin
         put(120 + 4 * i, NW[i], 1'b1, bmr_class_t'(4'(i)), 64'h1111_2222_3333_4444);
         i_bmr_client.read(FN_RD_HOLD, DS_FIRST + 120 + 4 * i, NW[i]);
         v = '0;
         for (int k = 0; k < NW[i]; k++) begin
            v = {v[47:0], w(k)};
         end
         check(v, SN[i]);
      end
      for (int i = 0; i < 2; i++) begin
         neutral_absent <= 1'b1 - 1'(i);
         put(200, 1, 1'b0, SC_NEUTRAL, 64'h1234);
         i_bmr_client.read(FN_RD_HOLD, 32200, 1);
         check(w(0), i == 0 ? 64'h8000 : 64'h1234);
      end
      for (int j = 0; j < 3; j++) begin
         i_bmr_client.read(FN_RD_HOLD, DS_FIRST + 125 * j, j < 2 ? 125 : 92);
         check(i_bmr_client.words.size(), j < 2 ? 125 : 92);
      end
      exc_case(8'h10, 32000, 1, EXC_ILL_FN);
      exc_case(FN_RD_HOLD, 32000, 0, EXC_ILL_VAL);
      exc_case(FN_RD_HOLD, 32000, 126, EXC_ILL_VAL);
      exc_case(FN_RD_HOLD, 32342, 1, EXC_ILL_ADDR);
      exc_case(FN_RD_INPUT, 32341, 2, EXC_ILL_ADDR);
      exc_case(FN_RD_HOLD, 2899, 1, EXC_ILL_ADDR);
      exc_case(FN_RD_HOLD, 32097, 2, EXC_ILL_ADDR);
      exc_case(FN_RD_HOLD, 32029, 1, EXC_ILL_ADDR);
      exc_case(FN_RD_INPUT, 2901, 2, EXC_ILL_ADDR);
      report_and_stop();
   end
   // Watchdog: the sequence needs about five hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule : tb_bmr_server
